// file: src/ias_slave.sv
// Purpose: i2c slave address receive, match, direction/collision status and scl stretching
// Assumes: scl/sda are open-drain, sampled by aclk through two flip-flops
// Notes: 7-bit own address; registers over axi4-lite; one level interrupt
`timescale 1ns/10ps
// Behaviour
// - optional smart mode, selected by a control bit, reduces software work.
// - stretch-select zero: hold scl low before or after acknowledge awaiting software.
// - stretch-select one: interrupts only after acknowledge has been sent.
// - stretch-select one, master read: address-match and data flags together after ack.
// - stretch-select one, master write: first data flag after first byte acked.
// - when enabled wait for start, then receive address and compare it.
// - mismatch: no acknowledge, return to waiting for start.
// - match sets the address-match flag.
// - stretch-select zero: scl held low until address-match flag is cleared.
// - direction status updated only on a matching address.
// - collision status shows the last addressed packet collided.
// - collision releases both lines silently; next match reveals it.
// - master read after accepted address: scl forced low.
// - master read: data-ready flag set once address acknowledged.
module ias_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ias_pkg::AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ias_pkg::AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic irq
);
   // line synchronisers and edge history
   logic scl_meta_r, scl_s_r, scl_d_r, sda_meta_r, sda_s_r, sda_d_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {scl_meta_r, scl_s_r, scl_d_r} <= 3'h7;
         {sda_meta_r, sda_s_r, sda_d_r} <= 3'h7;
      end else begin
         scl_meta_r <= scl_i;
         scl_s_r <= scl_meta_r;
         scl_d_r <= scl_s_r;
         sda_meta_r <= sda_i;
         sda_s_r <= sda_meta_r;
         sda_d_r <= sda_s_r;
      end
   end
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s_r & ~scl_d_r;
   assign scl_fall = ~scl_s_r & scl_d_r;
   assign start_det = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
   assign stop_det = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   // register bus state
   ias_pkg::ias_ctrl_t ctrl_r, ctrl_nxt;
   ias_pkg::ias_flags_t flags_r, flags_nxt, mask_r, mask_nxt, fset, fclr;
   ias_pkg::ias_status_t stat_r, stat_nxt;
   logic [6:0] own_r, own_nxt;
   logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, sh_r, sh_nxt;
   logic [ias_pkg::AW-1:0] wa_r, wa_nxt;
   logic [31:0] wd_r, wd_nxt, rdata_r, rdata_nxt;
   logic [3:0] ws_r, ws_nxt, cnt_r, cnt_nxt;
   logic awh_r, awh_nxt, wh_r, wh_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic pend_r, pend_nxt, scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
   logic do_wr, do_rd, addr_hit, transmit_collision_ev;
   ias_pkg::ias_state_t st_r, st_nxt;

   assign s_axi_awready = ~awh_r & ~bv_r;
   assign s_axi_wready = ~wh_r & ~bv_r;
   assign s_axi_arready = ~rv_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign scl_oe = scl_oe_r;
   assign sda_oe = sda_oe_r;
   assign irq = |(flags_r & mask_r);
   assign do_wr = awh_r & wh_r & ~bv_r;
   assign do_rd = s_axi_arvalid & ~rv_r;

   always_comb begin
      awh_nxt = awh_r;
      wh_nxt = wh_r;
      wa_nxt = wa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bv_nxt = bv_r;
      bresp_nxt = bresp_r;
      rv_nxt = rv_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      ctrl_nxt = ctrl_r;
      own_nxt = own_r;
      mask_nxt = mask_r;
      tx_nxt = tx_r;
      fclr = ias_pkg::FLAGS_ZERO;
      if (s_axi_awvalid && s_axi_awready) begin
         awh_nxt = 1'b1;
         wa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wh_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
         ws_nxt = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bv_nxt = 1'b0;
      end
      if (do_wr) begin
         awh_nxt = 1'b0;
         wh_nxt = 1'b0;
         bv_nxt = 1'b1;
         bresp_nxt = ias_pkg::RESP_OKAY;
         case (wa_r)
            ias_pkg::REG_CTRL: if (ws_r[0]) ctrl_nxt = wd_r[2:0];
            ias_pkg::REG_ADDR: if (ws_r[0]) own_nxt = wd_r[6:0];
            ias_pkg::REG_STATUS: bresp_nxt = ias_pkg::RESP_OKAY;
            ias_pkg::REG_FLAGS: if (ws_r[0]) fclr = wd_r[2:0];
            ias_pkg::REG_MASK: if (ws_r[0]) mask_nxt = wd_r[2:0];
            ias_pkg::REG_DATA: begin
               if (ws_r[0]) tx_nxt = wd_r[7:0];
               fclr.data_ready_flag = ctrl_r.smart_mode_enable;
            end
            default: bresp_nxt = ias_pkg::RESP_SLVERR;
         endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
         rv_nxt = 1'b0;
      end
      if (do_rd) begin
         rv_nxt = 1'b1;
         rresp_nxt = ias_pkg::RESP_OKAY;
         rdata_nxt = ias_pkg::WORD_ZERO;
         case (s_axi_araddr)
            ias_pkg::REG_CTRL: rdata_nxt[2:0] = ctrl_r;
            ias_pkg::REG_ADDR: rdata_nxt[6:0] = own_r;
            ias_pkg::REG_STATUS: rdata_nxt[1:0] = stat_r;
            ias_pkg::REG_FLAGS: rdata_nxt[2:0] = flags_r;
            ias_pkg::REG_MASK: rdata_nxt[2:0] = mask_r;
            ias_pkg::REG_DATA: begin
               rdata_nxt[7:0] = rx_r;
               if (ctrl_r.smart_mode_enable) fclr.data_ready_flag = 1'b1;
            end
            default: rresp_nxt = ias_pkg::RESP_SLVERR;
         endcase
      end
   end

   // bit engine
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      rx_nxt = rx_r;
      stat_nxt = stat_r;
      pend_nxt = pend_r;
      fset = ias_pkg::FLAGS_ZERO;
      addr_hit = 1'b0;
      transmit_collision_ev = 1'b0;
      case (st_r)
         ias_pkg::ST_IDLE: st_nxt = st_r;
         ias_pkg::ST_ADDR: begin
            if (scl_rise) begin
               sh_nxt = {sh_r[6:0], sda_s_r};
               cnt_nxt = cnt_r + ias_pkg::CNT_ONE;
            end
            if (scl_fall && cnt_r == ias_pkg::CNT_BYTE) begin
               st_nxt = ias_pkg::ST_IDLE;
               if (sh_r[7:1] == own_r) begin
                  addr_hit = 1'b1;
                  stat_nxt.dir = sh_r[0];
                  stat_nxt.transmit_collision = pend_r;
                  pend_nxt = 1'b0;
                  if (!ctrl_r.stretch_after_ack_select) begin
                     fset.address_match_flag = 1'b1;
                     st_nxt = ias_pkg::ST_ASTR;
                  end else begin
                     st_nxt = ias_pkg::ST_AACK;
                  end
               end
            end
         end
         ias_pkg::ST_ASTR: if (!flags_r.address_match_flag) st_nxt = ias_pkg::ST_AACK;
         ias_pkg::ST_AACK: if (scl_fall) begin
            cnt_nxt = ias_pkg::CNT_ZERO;
            if (stat_r.dir) begin
               fset.data_ready_flag = 1'b1;
               fset.address_match_flag = ctrl_r.stretch_after_ack_select;
               st_nxt = ias_pkg::ST_WAIT;
            end else begin
               fset.address_match_flag = ctrl_r.stretch_after_ack_select;
               st_nxt = ias_pkg::ST_RXB;
            end
         end
         ias_pkg::ST_WAIT: begin
            if (!flags_r.data_ready_flag && !flags_r.address_match_flag) begin
               cnt_nxt = ias_pkg::CNT_ZERO;
               st_nxt = stat_r.dir ? ias_pkg::ST_TXB : ias_pkg::ST_RXB;
               if (stat_r.dir) sh_nxt = tx_r;
            end
         end
         ias_pkg::ST_TXB: begin
            if (scl_rise) begin
               cnt_nxt = cnt_r + ias_pkg::CNT_ONE;
               if (sh_r[7] && !sda_s_r) begin
                  transmit_collision_ev = 1'b1;
                  pend_nxt = 1'b1;
                  st_nxt = ias_pkg::ST_IDLE;
               end
            end
            if (scl_fall) begin
               sh_nxt = {sh_r[6:0], 1'b1};
               if (cnt_r == ias_pkg::CNT_BYTE) st_nxt = ias_pkg::ST_TACK;
            end
         end
         ias_pkg::ST_TACK: begin
            if (scl_rise) begin
               cnt_nxt = ias_pkg::CNT_ACKD;
               if (sda_s_r) st_nxt = ias_pkg::ST_IDLE;
            end
            if (scl_fall && cnt_r == ias_pkg::CNT_ACKD) begin
               fset.data_ready_flag = 1'b1;
               st_nxt = ias_pkg::ST_WAIT;
            end
         end
         ias_pkg::ST_RXB: begin
            if (scl_rise) begin
               sh_nxt = {sh_r[6:0], sda_s_r};
               cnt_nxt = cnt_r + ias_pkg::CNT_ONE;
            end
            if (scl_fall && cnt_r == ias_pkg::CNT_BYTE) begin
               rx_nxt = sh_r;
               if (!ctrl_r.stretch_after_ack_select) begin
                  fset.data_ready_flag = 1'b1;
                  st_nxt = ias_pkg::ST_RSTR;
               end else begin
                  st_nxt = ias_pkg::ST_RACK;
               end
            end
         end
         ias_pkg::ST_RSTR: if (!flags_r.data_ready_flag) st_nxt = ias_pkg::ST_RACK;
         ias_pkg::ST_RACK: if (scl_fall) begin
            cnt_nxt = ias_pkg::CNT_ZERO;
            if (ctrl_r.stretch_after_ack_select) begin
               fset.data_ready_flag = 1'b1;
               st_nxt = ias_pkg::ST_WAIT;
            end else begin
               st_nxt = ias_pkg::ST_RXB;
            end
         end
         default: st_nxt = ias_pkg::ST_IDLE;
      endcase
      if (start_det) begin
         st_nxt = ias_pkg::ST_ADDR;
         cnt_nxt = ias_pkg::CNT_ZERO;
      end else if (stop_det) begin
         st_nxt = ias_pkg::ST_IDLE;
         fset.stop_flag = (st_r != ias_pkg::ST_IDLE) && (st_r != ias_pkg::ST_ADDR);
      end
      if (!ctrl_r.enable) st_nxt = ias_pkg::ST_IDLE;
      // set wins over a same-cycle clear
      flags_nxt = (flags_r & ~fclr) | fset;
      scl_oe_nxt = (st_nxt == ias_pkg::ST_ASTR) || (st_nxt == ias_pkg::ST_RSTR) ||
                   (st_nxt == ias_pkg::ST_WAIT);
      sda_oe_nxt = (st_nxt == ias_pkg::ST_AACK) || (st_nxt == ias_pkg::ST_RACK) ||
                   ((st_nxt == ias_pkg::ST_TXB) && !sh_nxt[7]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {awh_r, wh_r, bv_r, rv_r, pend_r, scl_oe_r, sda_oe_r} <= 7'h00;
         wa_r <= '0;
         {wd_r, rdata_r} <= {ias_pkg::WORD_ZERO, ias_pkg::WORD_ZERO};
         ws_r <= ias_pkg::CNT_ZERO;
         {bresp_r, rresp_r} <= {ias_pkg::RESP_OKAY, ias_pkg::RESP_OKAY};
         ctrl_r <= ias_pkg::CTRL_RST;
         own_r <= ias_pkg::OWN_ADDR_RST;
         {flags_r, mask_r} <= {ias_pkg::FLAGS_ZERO, ias_pkg::FLAGS_ZERO};
         stat_r <= 2'h0;
         {tx_r, rx_r, sh_r} <= {ias_pkg::BYTE_RST, ias_pkg::BYTE_RST, ias_pkg::BYTE_RST};
         cnt_r <= ias_pkg::CNT_ZERO;
         st_r <= ias_pkg::ST_IDLE;
      end else begin
         {awh_r, wh_r, bv_r, rv_r} <= {awh_nxt, wh_nxt, bv_nxt, rv_nxt};
         {pend_r, scl_oe_r, sda_oe_r} <= {pend_nxt, scl_oe_nxt, sda_oe_nxt};
         wa_r <= wa_nxt;
         wd_r <= wd_nxt;
         rdata_r <= rdata_nxt;
         ws_r <= ws_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         ctrl_r <= ctrl_nxt;
         own_r <= own_nxt;
         flags_r <= flags_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic a_fall8;
   assign a_fall8 = (st_r == ias_pkg::ST_ADDR) && scl_fall && (cnt_r == ias_pkg::CNT_BYTE) &&
                    !start_det && !stop_det && ctrl_r.enable;
   property p_nomatch;
      a_fall8 && (sh_r[7:1] != own_r) |=> (st_r == ias_pkg::ST_IDLE) && !sda_oe ##1 !sda_oe;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("mismatch not rejected");
   property p_match;
      a_fall8 && (sh_r[7:1] == own_r) && !ctrl_r.stretch_after_ack_select
         |=> flags_r.address_match_flag && scl_oe;
   endproperty
   a_match: assert property (p_match) else $error("match flag missing");
   property p_hold;
      (st_r == ias_pkg::ST_ASTR) && flags_r.address_match_flag |-> scl_oe && !sda_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("scl not held for match");
   property p_release;
      (st_r == ias_pkg::ST_ASTR) && !flags_r.address_match_flag && ctrl_r.enable && !start_det
         && !stop_det |=> !scl_oe && sda_oe;
   endproperty
   a_release: assert property (p_release) else $error("scl not released");
   property p_dir;
      $changed(stat_r.dir) |-> $past(addr_hit);
   endproperty
   a_dir: assert property (p_dir) else $error("dir changed without match");
   // own record of collisions since the last match, kept apart from pend_r
   logic transmit_collision_seen_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) transmit_collision_seen_r <= 1'b0;
      else transmit_collision_seen_r <= transmit_collision_ev | (transmit_collision_seen_r & ~addr_hit);
   end
   property p_transmit_collision_stat;
      addr_hit |=> (stat_r.transmit_collision == $past(transmit_collision_seen_r));
   endproperty
   a_transmit_collision_stat: assert property (p_transmit_collision_stat) else $error("collision status wrong");
   property p_silent;
      transmit_collision_ev |=> !scl_oe && !sda_oe && ((flags_r & ~$past(flags_r)) == ias_pkg::FLAGS_ZERO);
   endproperty
   a_silent: assert property (p_silent) else $error("collision not silent");
   property p_read;
      (st_r == ias_pkg::ST_AACK) && stat_r.dir && scl_fall && ctrl_r.enable && !stop_det
         |=> scl_oe && flags_r.data_ready_flag
         && (flags_r.address_match_flag || !$past(ctrl_r.stretch_after_ack_select));
   endproperty
   a_read: assert property (p_read) else $error("read ack not stretched");
   property p_wr_sm;
      (st_r == ias_pkg::ST_AACK) && !stat_r.dir && scl_fall && ctrl_r.enable && !stop_det
         && !start_det |=> (st_r == ias_pkg::ST_RXB) && !scl_oe;
   endproperty
   a_wr_sm: assert property (p_wr_sm) else $error("write ack stretched");
   property p_rx_stretch;
      (st_r == ias_pkg::ST_RSTR) |-> scl_oe && !sda_oe;
   endproperty
   a_rx_stretch: assert property (p_rx_stretch) else $error("no stretch before ack");
   property p_start;
      start_det && ctrl_r.enable |=> (st_r == ias_pkg::ST_ADDR) && (cnt_r == ias_pkg::CNT_ZERO);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   c_match: cover property (addr_hit);
   c_read: cover property ((st_r == ias_pkg::ST_TXB) ##[1:1000] (st_r == ias_pkg::ST_TACK));
   c_transmit_collision: cover property (transmit_collision_ev);
   c_wsm: cover property (ctrl_r.stretch_after_ack_select && (st_r == ias_pkg::ST_RACK));
endmodule : ias_slave

// file: src/ias_pkg.sv
// Purpose: shared constants, register map and types of the i2c address/stretch slave
// Assumes: 32-bit axi4-lite register bus, one register per aligned word
// Notes: register fields sit in the low bits, upper bits read as zero
package ias_pkg;
   localparam int AW = 8;
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_ADDR = 8'h04;
   localparam logic [AW-1:0] REG_STATUS = 8'h08;
   localparam logic [AW-1:0] REG_FLAGS = 8'h0C;
   localparam logic [AW-1:0] REG_MASK = 8'h10;
   localparam logic [AW-1:0] REG_DATA = 8'h14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [6:0] OWN_ADDR_RST = 7'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_BYTE = 4'h8;
   localparam logic [3:0] CNT_ACKD = 4'h9;

   typedef struct packed {
      logic stretch_after_ack_select;
      logic smart_mode_enable;
      logic enable;
   } ias_ctrl_t;

   typedef struct packed {
      logic transmit_collision;
      logic dir;
   } ias_status_t;

   typedef struct packed {
      logic stop_flag;
      logic data_ready_flag;
      logic address_match_flag;
   } ias_flags_t;

   localparam ias_ctrl_t CTRL_RST = 3'h0;
   localparam ias_flags_t FLAGS_ZERO = 3'h0;

   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_ADDR = 10'h002,
      ST_ASTR = 10'h004,
      ST_AACK = 10'h008,
      ST_TXB = 10'h010,
      ST_TACK = 10'h020,
      ST_RXB = 10'h040,
      ST_RSTR = 10'h080,
      ST_RACK = 10'h100,
      ST_WAIT = 10'h200
   } ias_state_t;
endpackage : ias_pkg

// file: testbench/ias_i2c_master.sv
// Purpose: behavioural i2c bus master facing the address/stretch slave
// Assumes: open-drain lines with pull-ups resolved in the bench
// Notes: scl stands still low between bytes and high between frames
`timescale 1ns/10ps
module ias_i2c_master (
   output logic scl_oe,
   output logic sda_oe,
   input wire logic scl,
   input wire logic sda,
   output logic hung
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      hung = 1'b0;
   end

   // low phase is long enough that a stretch starts before scl is let go
   task automatic bit_x(input logic b, output logic r);
      int n;
      #20;
      sda_oe = !b;
      #42;
      scl_oe = 1'b0;
      for (n = 0; n < 4000 && scl !== 1'b1; n++) #10;
      if (n == 4000) hung = 1'b1;
      #31;
      r = sda;
      #31;
      scl_oe = 1'b1;
   endtask : bit_x

   task automatic send_start();
      #62;
      sda_oe = 1'b1;
      #62;
      scl_oe = 1'b1;
   endtask : send_start

   // sda must rise while scl is high, so scl is let go first and any stretch waited out
   task automatic send_stop();
      int n;
      #20;
      sda_oe = 1'b1;
      #42;
      scl_oe = 1'b0;
      for (n = 0; n < 4000 && scl !== 1'b1; n++) #10;
      if (n == 4000) hung = 1'b1;
      #62;
      sda_oe = 1'b0;
      #62;
   endtask : send_stop

   // ten-bit header: 11110, upper two address bits, then direction
   function automatic logic [7:0] ten_bit_head(input logic [9:0] a, input logic rd);
      return {5'h1E, a[9:8], rd};
   endfunction : ten_bit_head

   task automatic write_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(d[i], ack);
      bit_x(1'b1, ack);
   endtask : write_byte

   // clash pulls sda low under the slave's ones to provoke a collision
   task automatic read_byte(input logic clash, input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(!clash, d[i]);
      bit_x(nack, r);
   endtask : read_byte
endmodule : ias_i2c_master

// file: testbench/tb.sv
// Purpose: register-level test of the i2c address/stretch slave
// Assumes: own address 0x2a, then 0x79 for the last frame, master model on the far side of the bus
// Notes: every wait is bounded; a spent bound ends the run as failed
`timescale 1ns/10ps
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, hung, irq, ack;
   logic [7:0] d8;
   wire logic scl_line = !(scl_oe | m_scl_oe);
   wire logic sda_line = !(sda_oe | m_sda_oe);
   int mismatches = 0;
   int comparisons = 0;

   always #5 aclk = !aclk;

   ias_slave u_ias_slave (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl_line), .scl_o(),
      .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .irq(irq));

   ias_i2c_master u_ias_i2c_master (.scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .scl(scl_line),
      .sda(sda_line), .hung(hung));

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check_bit

   task automatic timed_out();
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, 1'b0, 1'b1);
      complete_run();
   endtask : timed_out

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) timed_out();
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) timed_out();
   endtask : axi_rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a);
      check(d, exp);
   endtask : rd_chk

   task automatic wait_irq();
      int n;
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge aclk);
      if (n == 3000) timed_out();
   endtask : wait_irq

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(ias_pkg::REG_CTRL, 32'h0000_0000);
      rd_chk(ias_pkg::REG_STATUS, 32'h0000_0000);
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0000);
      axi_rd(8'h40);
      check({30'h0000_0000, r}, 32'h0000_0002);
      axi_wr(8'h40, 32'h0000_0000);
      check({30'h0000_0000, r}, 32'h0000_0002);
      axi_wr(ias_pkg::REG_ADDR, 32'h0000_002A);
      axi_wr(ias_pkg::REG_MASK, 32'h0000_0007);
      axi_wr(ias_pkg::REG_CTRL, 32'h0000_0003);
      u_ias_i2c_master.send_start();
      u_ias_i2c_master.write_byte(u_ias_i2c_master.ten_bit_head(10'h1C3, 1'b0), ack);
      check_bit(ack, 1'b1);
      u_ias_i2c_master.send_stop();
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0000);
      u_ias_i2c_master.send_start();
      fork
         u_ias_i2c_master.write_byte(8'h54, ack);
         begin
            wait_irq();
            rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0001);
            check_bit(scl_line, 1'b0);
            rd_chk(ias_pkg::REG_STATUS, 32'h0000_0000);
            axi_wr(ias_pkg::REG_MASK, 32'h0000_0000);
            check_bit(irq, 1'b0);
            axi_wr(ias_pkg::REG_MASK, 32'h0000_0007);
            axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0001);
         end
      join
      check_bit(ack, 1'b0);
      fork
         u_ias_i2c_master.write_byte(8'hA5, ack);
         begin
            wait_irq();
            rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0002);
            rd_chk(ias_pkg::REG_DATA, 32'h0000_00A5);
         end
      join
      check_bit(ack, 1'b0);
      u_ias_i2c_master.send_stop();
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0004);
      axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0007);
      axi_wr(ias_pkg::REG_CTRL, 32'h0000_0001);
      u_ias_i2c_master.send_start();
      fork
         u_ias_i2c_master.write_byte(8'h55, ack);
         begin
            wait_irq();
            rd_chk(ias_pkg::REG_STATUS, 32'h0000_0001);
            check_bit(scl_line, 1'b0);
            axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0001);
         end
      join
      fork
         u_ias_i2c_master.read_byte(1'b0, 1'b1, d8);
         begin
            wait_irq();
            rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0002);
            axi_wr(ias_pkg::REG_DATA, 32'h0000_003C);
            axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0002);
         end
      join
      check({24'h00_0000, d8}, 32'h0000_003C);
      u_ias_i2c_master.send_stop();
      axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0007);
      axi_wr(ias_pkg::REG_CTRL, 32'h0000_0005);
      u_ias_i2c_master.send_start();
      u_ias_i2c_master.write_byte(8'h55, ack);
      check_bit(ack, 1'b0);
      wait_irq();
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0003);
      fork
         u_ias_i2c_master.read_byte(1'b1, 1'b1, d8);
         begin
            axi_wr(ias_pkg::REG_DATA, 32'h0000_00FF);
            axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0003);
         end
      join
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0000);
      check_bit(scl_oe | sda_oe, 1'b0);
      rd_chk(ias_pkg::REG_STATUS, 32'h0000_0001);
      u_ias_i2c_master.send_stop();
      axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0007);
      u_ias_i2c_master.send_start();
      u_ias_i2c_master.write_byte(8'h54, ack);
      check_bit(ack, 1'b0);
      wait_irq();
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0001);
      rd_chk(ias_pkg::REG_STATUS, 32'h0000_0002);
      axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0001);
      u_ias_i2c_master.write_byte(8'h81, ack);
      check_bit(ack, 1'b0);
      wait_irq();
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0002);
      rd_chk(ias_pkg::REG_DATA, 32'h0000_0081);
      axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0002);
      u_ias_i2c_master.send_stop();
      axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0007);
      axi_wr(ias_pkg::REG_ADDR, 32'h0000_0079);
      axi_wr(ias_pkg::REG_CTRL, 32'h0000_0007);
      u_ias_i2c_master.send_start();
      u_ias_i2c_master.write_byte(u_ias_i2c_master.ten_bit_head(10'h1C3, 1'b1), ack);
      check_bit(ack, 1'b0);
      wait_irq();
      rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0003);
      rd_chk(ias_pkg::REG_STATUS, 32'h0000_0001);
      fork
         u_ias_i2c_master.read_byte(1'b0, 1'b1, d8);
         begin
            axi_wr(ias_pkg::REG_DATA, 32'h0000_005A);
            rd_chk(ias_pkg::REG_FLAGS, 32'h0000_0001);
            axi_wr(ias_pkg::REG_FLAGS, 32'h0000_0001);
         end
      join
      check({24'h00_0000, d8}, 32'h0000_005A);
      u_ias_i2c_master.send_stop();
      check_bit(hung, 1'b0);
      complete_run();
   end
endmodule : tb
